// ---- can_filter_buffer_routing_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module can_filter_buffer_routing_test;
   logic clock = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0;
   logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, fire = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, hit_valid;
   logic dest_valid, dest_to_fifo;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [3:0] fire_filter = 4'h0, hit_filter, dest_select, fld;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] s47 = 16'hf1e0, s811 = 16'h73c9;
   int fails = 0, n_tests = 0, i;
   always #5 clock = ~clock;
   cfbr_top dut_u (.clock, .rst, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .hit_valid, .hit_filter,
      .dest_valid, .dest_select, .dest_to_fifo);
   cfbr_filter_model far_u (.clock, .rst, .fire, .fire_filter, .hit_valid,
      .hit_filter);
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // Readies are sampled mid-cycle; inputs only move on rising edges
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      logic ta, tw, v;
      int k;
      ta = 1'h0;
      tw = !w;
      v = 1'h0;
      @(posedge clock);
      if (w) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
      end else begin
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
      end
      for (k = 0; k < 20 && !v; k++) begin
         @(negedge clock);
         ta = ta | (awvalid & awready) | (arvalid & arready);
         tw = tw | (wvalid & wready);
         v = w ? bvalid : rvalid;
         rs = w ? bresp : rresp;
         rd = rdata;
         @(posedge clock);
         if (ta) awvalid <= 1'h0;
         if (ta) arvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (v) bready <= 1'h0;
         if (v) rready <= 1'h0;
      end
      if (!v) begin
         fails++;
         conclude();
      end
   endtask : bus
   task automatic hit(input logic [3:0] f);
      @(posedge clock);
      fire <= 1'h1;
      fire_filter <= f;
      @(posedge clock);
      fire <= 1'h0;
      @(posedge clock);
      @(negedge clock);
   endtask : hit
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'h0;
      bus(1'h0, cfbr_pkg::ADDR_SEL47, 32'h0);
      `CHK("sel47 reset", 32'h0, rd)
      bus(1'h0, cfbr_pkg::ADDR_SEL811, 32'h0);
      `CHK("sel811 reset", 32'h0, rd)
      $display("test reset done");
      bus(1'h1, cfbr_pkg::ADDR_SEL47, {16'hffff, s47});
      `CHK("wr resp", cfbr_pkg::RESP_OKAY, rs)
      bus(1'h1, cfbr_pkg::ADDR_SEL811, {16'h0, s811});
      bus(1'h0, cfbr_pkg::ADDR_SEL47, 32'h0);
      `CHK("sel47", {16'h0, s47}, rd)
      bus(1'h0, cfbr_pkg::ADDR_SEL811, 32'h0);
      `CHK("sel811", {16'h0, s811}, rd)
      $display("test access done");
      for (i = 3; i < 13; i++) begin
         hit(i[3:0]);
         fld = 4'(((i < 8) ? s47 : s811) >> (4 * (i % 4)));
         `CHK("valid", (i > 3 && i < 12), dest_valid)
         if (dest_valid === 1'h1) begin
            `CHK("select", fld, dest_select)
            `CHK("fifo", fld == cfbr_pkg::DEST_FIFO, dest_to_fifo)
         end
      end
      $display("test routing done");
      bus(1'h0, cfbr_pkg::ADDR_HIT, 32'h0);
      `CHK("last hit", 32'(cfbr_pkg::FILT_LAST), rd)
      wstrb <= 4'h2;
      bus(1'h1, cfbr_pkg::ADDR_SEL811, 32'h0000ab00);
      wstrb <= 4'hf;
      `CHK("lane resp", cfbr_pkg::RESP_OKAY, rs)
      bus(1'h0, cfbr_pkg::ADDR_SEL811, 32'h0);
      `CHK("lane sel811", 32'habc9, rd)
      bus(1'h1, 4'hc, 32'h0);
      `CHK("unmapped wr", cfbr_pkg::RESP_SLVERR, rs)
      bus(1'h0, 4'hc, 32'h0);
      `CHK("unmapped resp", cfbr_pkg::RESP_SLVERR, rs)
      `CHK("unmapped data", 32'h0, rd)
      $display("test unmapped done");
      rst <= 1'h1;
      repeat (2) @(posedge clock);
      rst <= 1'h0;
      bus(1'h0, cfbr_pkg::ADDR_SEL811, 32'h0);
      `CHK("sel811 rerun", 32'h0, rd)
      bus(1'h0, cfbr_pkg::ADDR_SEL47, 32'h0);
      `CHK("sel47 rerun", 32'h0, rd)
      $display("test rerun reset done");
      conclude();
   end
endmodule : can_filter_buffer_routing_test

// ---- cfbr_filter_model.sv ----
`timescale 1ns/100ps
module cfbr_filter_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic fire,
   input wire logic [3:0] fire_filter,
   output logic hit_valid,
   output logic [3:0] hit_filter
);
   // Filter number churns between hits so a stale value is never trusted
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         hit_valid <= 1'h0;
         hit_filter <= 4'h0;
      end else begin
         hit_valid <= fire;
         hit_filter <= fire ? fire_filter : ~hit_filter;
      end
   end
endmodule : cfbr_filter_model

// ---- cfbr_pkg.sv ----
package cfbr_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_SEL47 = 4'h0;
   localparam logic [3:0] ADDR_SEL811 = 4'h4;
   localparam logic [3:0] ADDR_HIT = 4'h8;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam int FIELD_W = 4;
   localparam logic [3:0] DEST_FIFO = 4'hf;
   localparam logic [3:0] FILT_FIRST = 4'h4;
   localparam logic [3:0] FILT_MID = 4'h8;
   localparam logic [3:0] FILT_LAST = 4'hb;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cfbr_pkg

// ---- cfbr_top.sv ----
`timescale 1ns/100ps
// Functional notes
// - All-ones field routes hits to receive FIFO
// - Codes one to fourteen select that buffer
// - Zero field selects receive buffer zero
// - Register zero holds filters 7..4, high first
// - Both registers read/write, reset to zero
module cfbr_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic hit_valid,
   input wire logic [3:0] hit_filter,
   output logic dest_valid,
   output logic [3:0] dest_select,
   output logic dest_to_fifo
);
   logic [15:0] sel47_ff, nxt_sel47, sel811_ff, nxt_sel811;
   logic aw_ff, nxt_aw, w_ff, nxt_w;
   logic [3:0] awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd;
   logic [3:0] ws_ff, nxt_ws;
   logic bv_ff, nxt_bv, rv_ff, nxt_rv;
   logic awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, arrdy_ff, nxt_arrdy;
   logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
   logic [31:0] rd_ff, nxt_rd;
   logic dv_ff, nxt_dv, df_ff, nxt_df;
   logic [3:0] ds_ff, nxt_ds;
   logic [3:0] last_hit_ff, nxt_last_hit;

   // Picks field n of a packed four-field selector
   function automatic logic [3:0] cfbr_field(input logic [15:0] r,
                                             input logic [1:0] n);
      cfbr_field = r[n*cfbr_pkg::FIELD_W +: cfbr_pkg::FIELD_W];
   endfunction : cfbr_field

   function automatic logic [15:0] cfbr_merge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
      cfbr_merge = old;
      if (s[0]) cfbr_merge[7:0] = d[7:0];
      if (s[1]) cfbr_merge[15:8] = d[15:8];
   endfunction : cfbr_merge

   always_comb begin
      nxt_aw = aw_ff;
      nxt_w = w_ff;
      nxt_awa = awa_ff;
      nxt_wd = wd_ff;
      nxt_ws = ws_ff;
      nxt_bv = bv_ff;
      nxt_br = br_ff;
      nxt_sel47 = sel47_ff;
      nxt_sel811 = sel811_ff;
      if (awvalid && !aw_ff && !bv_ff) begin
         nxt_aw = 1'b1;
         nxt_awa = awaddr;
      end
      if (wvalid && !w_ff && !bv_ff) begin
         nxt_w = 1'b1;
         nxt_wd = wdata;
         nxt_ws = wstrb;
      end
      if (aw_ff && w_ff) begin
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = cfbr_pkg::RESP_OKAY;
         case (awa_ff)
            cfbr_pkg::ADDR_SEL47: begin
               nxt_sel47 = cfbr_merge(sel47_ff, wd_ff, ws_ff);
            end
            cfbr_pkg::ADDR_SEL811: begin
               nxt_sel811 = cfbr_merge(sel811_ff, wd_ff, ws_ff);
            end
            cfbr_pkg::ADDR_HIT: begin
               nxt_br = cfbr_pkg::RESP_OKAY;
            end
            default: begin
               nxt_br = cfbr_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (bv_ff && bready) begin
         nxt_bv = 1'b0;
      end
      // Readies come from next state so the bus sees flop outputs only
      nxt_awrdy = !nxt_aw && !nxt_bv;
      nxt_wrdy = !nxt_w && !nxt_bv;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awa_ff <= 4'h0;
         wd_ff <= 32'h0;
         ws_ff <= 4'h0;
         bv_ff <= 1'b0;
         br_ff <= 2'h0;
         awrdy_ff <= 1'b1;
         wrdy_ff <= 1'b1;
         sel47_ff <= cfbr_pkg::SEL_RESET;
         sel811_ff <= cfbr_pkg::SEL_RESET;
      end else begin
         aw_ff <= nxt_aw;
         w_ff <= nxt_w;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         ws_ff <= nxt_ws;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         awrdy_ff <= nxt_awrdy;
         wrdy_ff <= nxt_wrdy;
         sel47_ff <= nxt_sel47;
         sel811_ff <= nxt_sel811;
      end
   end

   always_comb begin
      nxt_rv = rv_ff;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (rv_ff && rready) begin
         nxt_rv = 1'b0;
      end
      if (arvalid && !rv_ff) begin
         nxt_rv = 1'b1;
         nxt_rr = cfbr_pkg::RESP_OKAY;
         case (araddr)
            cfbr_pkg::ADDR_SEL47: nxt_rd = {16'h0000, sel47_ff};
            cfbr_pkg::ADDR_SEL811: nxt_rd = {16'h0000, sel811_ff};
            cfbr_pkg::ADDR_HIT: nxt_rd = {28'h0000000, last_hit_ff};
            default: begin
               nxt_rd = 32'h0;
               nxt_rr = cfbr_pkg::RESP_SLVERR;
            end
         endcase
      end
      nxt_arrdy = !nxt_rv;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rv_ff <= 1'b0;
         rd_ff <= 32'h0;
         rr_ff <= 2'h0;
         arrdy_ff <= 1'b1;
      end else begin
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         rr_ff <= nxt_rr;
         arrdy_ff <= nxt_arrdy;
      end
   end

   // Hits on filters outside 4..11 belong to neighbouring blocks and are
   // ignored here, so dest_valid only answers for this block's filters.
   always_comb begin
      nxt_dv = 1'b0;
      nxt_ds = ds_ff;
      nxt_df = df_ff;
      nxt_last_hit = last_hit_ff;
      if (hit_valid && hit_filter >= cfbr_pkg::FILT_FIRST &&
          hit_filter <= cfbr_pkg::FILT_LAST) begin
         nxt_dv = 1'b1;
         nxt_last_hit = hit_filter;
         if (hit_filter < cfbr_pkg::FILT_MID) begin
            nxt_ds = cfbr_field(sel47_ff, hit_filter[1:0]);
         end else begin
            nxt_ds = cfbr_field(sel811_ff, hit_filter[1:0]);
         end
         // Codes 0..14 name the buffer directly, all-ones means FIFO
         nxt_df = (nxt_ds == cfbr_pkg::DEST_FIFO);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dv_ff <= 1'b0;
         ds_ff <= 4'h0;
         df_ff <= 1'b0;
         last_hit_ff <= 4'h0;
      end else begin
         dv_ff <= nxt_dv;
         ds_ff <= nxt_ds;
         df_ff <= nxt_df;
         last_hit_ff <= nxt_last_hit;
      end
   end

   assign awready = awrdy_ff;
   assign wready = wrdy_ff;
   assign bvalid = bv_ff;
   assign bresp = br_ff;
   assign arready = arrdy_ff;
   assign rvalid = rv_ff;
   assign rdata = rd_ff;
   assign rresp = rr_ff;
   assign dest_valid = dv_ff;
   assign dest_select = ds_ff;
   assign dest_to_fifo = df_ff;

   sequence s_hit_lo;
      hit_valid && hit_filter >= cfbr_pkg::FILT_FIRST &&
         hit_filter < cfbr_pkg::FILT_MID;
   endsequence
   sequence s_hit_hi;
      hit_valid && hit_filter >= cfbr_pkg::FILT_MID &&
         hit_filter <= cfbr_pkg::FILT_LAST;
   endsequence

   chk_fifo_flag: assert property (@(posedge clock) disable iff (rst)
      (s_hit_lo ##0
      (cfbr_field(sel47_ff, hit_filter[1:0]) == cfbr_pkg::DEST_FIFO))
      |=> (dv_ff && df_ff && ds_ff == cfbr_pkg::DEST_FIFO))
      else $error("fifo code not routed to fifo");
   chk_buffer_num: assert property (@(posedge clock) disable iff (rst)
      (s_hit_hi ##0
      (cfbr_field(sel811_ff, hit_filter[1:0]) != cfbr_pkg::DEST_FIFO))
      |=> (dv_ff && !df_ff))
      else $error("buffer code sent to fifo");
   chk_zero_code: assert property (@(posedge clock) disable iff (rst)
      (s_hit_lo ##0 (cfbr_field(sel47_ff, hit_filter[1:0]) == 4'h0))
      |=> (dv_ff && ds_ff == 4'h0 && !df_ff))
      else $error("zero code not buffer zero");
   chk_lo_lookup: assert property (@(posedge clock) disable iff (rst)
      s_hit_lo |=> (dv_ff &&
      ds_ff == $past(cfbr_field(sel47_ff, hit_filter[1:0]))))
      else $error("filter 4..7 lookup wrong");
   chk_hi_lookup: assert property (@(posedge clock) disable iff (rst)
      s_hit_hi |=> (dv_ff &&
      ds_ff == $past(cfbr_field(sel811_ff, hit_filter[1:0]))))
      else $error("filter 8..11 lookup wrong");
   chk_reg_write: assert property (@(posedge clock) disable iff (rst)
      (aw_ff && w_ff && awa_ff == cfbr_pkg::ADDR_SEL47 &&
      ws_ff[1:0] == 2'h3) |=> (sel47_ff == $past(wd_ff[15:0])))
      else $error("selector write lost");
   chk_reg_read: assert property (@(posedge clock) disable iff (rst)
      (arvalid && arready && araddr == cfbr_pkg::ADDR_SEL811)
      |=> (rvalid && rdata == {16'h0000, $past(sel811_ff)}))
      else $error("selector read wrong");
   chk_hit_pulse: assert property (@(posedge clock) disable iff (rst)
      dv_ff |-> $past(hit_valid))
      else $error("destination without hit");
   chk_foreign_hit: assert property (@(posedge clock) disable iff (rst)
      (hit_valid && (hit_filter < cfbr_pkg::FILT_FIRST ||
      hit_filter > cfbr_pkg::FILT_LAST)) |=> !dv_ff)
      else $error("foreign filter hit answered");
endmodule : cfbr_top
